// File: lpn_pkg.sv
// Purpose: Shared constants and types for the low-power and parameter
//          memory controller of a sensorless motor driver.
// Assumes: 125 MHz system clock, 8-bit register port.
// Notes:   Qualification times are plain defaults until characterised.
`default_nettype none

package lpn_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_FREQ_MHZ = 125;
  localparam int QUAL_W = 12;
  localparam int T_EN_SB_ANA_US = 20;
  localparam int T_EN_SL_ANA_US = 20;
  localparam int T_EX_SB_ANA_US = 10;
  localparam int T_EX_SL_ANA_US = 10;
  localparam int T_EN_SB_PWM_US = 30;
  localparam int T_EN_SL_PWM_US = 30;
  localparam int T_EX_SB_PWM_US = 10;
  localparam int T_EX_SL_PWM_US = 10;
  localparam logic [QUAL_W-1:0] EN_SB_ANA_CYC =
    QUAL_W'(T_EN_SB_ANA_US * CLK_FREQ_MHZ);
  localparam logic [QUAL_W-1:0] EN_SL_ANA_CYC =
    QUAL_W'(T_EN_SL_ANA_US * CLK_FREQ_MHZ);
  localparam logic [QUAL_W-1:0] EX_SB_ANA_CYC =
    QUAL_W'(T_EX_SB_ANA_US * CLK_FREQ_MHZ);
  localparam logic [QUAL_W-1:0] EX_SL_ANA_CYC =
    QUAL_W'(T_EX_SL_ANA_US * CLK_FREQ_MHZ);
  localparam logic [QUAL_W-1:0] EN_SB_PWM_CYC =
    QUAL_W'(T_EN_SB_PWM_US * CLK_FREQ_MHZ);
  localparam logic [QUAL_W-1:0] EN_SL_PWM_CYC =
    QUAL_W'(T_EN_SL_PWM_US * CLK_FREQ_MHZ);
  localparam logic [QUAL_W-1:0] EX_SB_PWM_CYC =
    QUAL_W'(T_EX_SB_PWM_US * CLK_FREQ_MHZ);
  localparam logic [QUAL_W-1:0] EX_SL_PWM_CYC =
    QUAL_W'(T_EX_SL_PWM_US * CLK_FREQ_MHZ);
  localparam int NVM_WRITE_TIME_US = 24000;
  localparam int NVM_WRITE_CYCLES_DFLT = NVM_WRITE_TIME_US * CLK_FREQ_MHZ;

  // ==========================================================
  // Analog speed thresholds, exit from sleep above exit from standby
  localparam logic [8:0] LVL_EN_SB = 9'h010;
  localparam logic [8:0] LVL_EN_SL = 9'h010;
  localparam logic [8:0] LVL_EX_SB = 9'h020;
  localparam logic [8:0] LVL_EX_SL = 9'h040;
  localparam logic [8:0] DUTY_FULL = 9'h100;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_SPEED_LO = 8'h00;
  localparam logic [7:0] ADDR_SPEED_HI = 8'h01;
  localparam logic [7:0] ADDR_CONFIG = 8'h02;
  localparam logic [7:0] ADDR_DEV_CTRL = 8'h03;
  localparam logic [7:0] ADDR_NVM_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_PARAM_BASE = 8'h20;
  localparam logic [7:0] ADDR_PARAM_LAST = 8'h2b;
  localparam int PARAM_BYTES = 12;
  localparam int NVM_BITS = 96;
  localparam int PARAM_RES_IDX = 0;
  localparam int PARAM_KT_IDX = 1;
  localparam int PARAM_MODE_IDX = 11;
  localparam int MODE_LSB = 0;
  localparam int CFG_INHIBIT_BIT = 7;
  localparam int NVMC_START_BIT = 0;
  localparam int NVMC_SELECT_BIT = 6;
  localparam int STAT_LOW_POWER_BIT = 6;
  localparam logic [7:0] PROGRAM_KEY = 8'hb6;
  localparam logic [8:0] SPEED_RST = 9'h000;
  localparam logic [7:0] KEY_RST = 8'h00;
  localparam logic INHIBIT_RST = 1'b0;
  localparam logic SELECT_RST = 1'b0;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    MODE_ANALOG, MODE_PWM, MODE_REG_PWM_PIN, MODE_REG_ANA_PIN
  } lpn_mode_t;
  typedef enum {ST_LOAD, ST_ACTIVE, ST_LOW_POWER} lpn_pwr_state_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } lpn_bus_req_t;
  typedef logic signed [7:0] lpn_sample_t;
  typedef lpn_sample_t [2:0] lpn_wave_t;
  typedef logic [2:0][7:0] lpn_duty_t;

endpackage

`default_nettype wire

// File: lpn_qual_timer.sv
// Purpose: Qualification timer, reports a condition held for a count.
// Assumes: limit is at least one.
// Notes:   Any lapse of the condition or the arm restarts the count.
`default_nettype none

module lpn_qual_timer #(
  parameter int W = 12
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic arm,
  input wire logic cond,
  input wire logic [W-1:0] limit,
  output logic done
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // ==========================================================
  // Count
  always_comb begin
    cnt_next = cnt_reg;
    if (!(arm && cond)) begin
      cnt_next = '0;
    end else if (cnt_reg != limit) begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
    end else if (ce) begin
      cnt_reg <= cnt_next;
    end
  end

  assign done = arm && cond && (cnt_reg == limit);

endmodule

`default_nettype wire

// File: lpn_drive_shaper.sv
// Purpose: Scales the phase waveform by the peak duty and clamps the
//          lowest phase to ground.
// Assumes: duty is at most full scale (0x100 means 100 percent).
// Notes:   Outputs are registered, one cycle after the inputs.
`default_nettype none

module lpn_drive_shaper
  import lpn_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic drive_on,
  input wire logic [8:0] duty,
  input wire logic [7:0] supply,
  input wire lpn_wave_t wave,
  output logic [7:0] amplitude,
  output lpn_duty_t phase_duty
);

  logic signed [9:0] scaled [3];
  logic signed [9:0] floor_val;
  logic [16:0] amp_prod;
  logic [7:0] amp_reg;
  logic [7:0] amp_next;
  lpn_duty_t duty_reg;
  lpn_duty_t duty_next;

  // ==========================================================
  // Per-phase scaling and shift to ground
  generate
    for (genvar p = 0; p < 3; p++) begin : g_phase
      logic signed [17:0] prod;
      assign prod = $signed(wave[p]) * $signed({1'b0, duty});
      assign scaled[p] = 10'(prod >>> 8);
      // Subtracting the common minimum adds the third harmonic term.
      assign duty_next[p] = drive_on ?
        8'(scaled[p] - floor_val) : 8'h00;
    end
  endgenerate

  always_comb begin
    floor_val = scaled[0];
    if (scaled[1] < floor_val) begin
      floor_val = scaled[1];
    end
    if (scaled[2] < floor_val) begin
      floor_val = scaled[2];
    end
    amp_prod = supply * duty;
    // Full scale duty gives the whole supply, half scale gives half.
    amp_next = drive_on ? 8'(amp_prod >> 8) : 8'h00;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      amp_reg <= '0;
      duty_reg <= '0;
    end else if (ce) begin
      amp_reg <= amp_next;
      duty_reg <= duty_next;
    end
  end

  assign amplitude = amp_reg;
  assign phase_duty = duty_reg;

endmodule

`default_nettype wire

// File: lpn_power_ctrl.sv
// Purpose: Low-power entry and exit, register port and parameter
//          memory programming for a sensorless motor driver.
// Assumes: speed_level is the digitised speed pin (analog level or
//          measured duty), speed_pin its logic level.
// Notes:   rstn stands for power-on; the parameter memory array is not
//          cleared by it and starts from NVM_INIT.
`default_nettype none

// Overview of operation
// - Amplitude scales linearly with peak duty
// - Lowest phase grounded, other two modulated
// - Low power stops motor drive
// - Sleep: regulator, serial off, volatile regs reset
// - Standby: regulator on, registers kept, port live
// - Inhibit blocks entry, never forces exit
// - Status bit 6 set while low power
// - Analog mode: threshold held for time
// - Pulse-width mode: level held for time
// - Register mode enters on zero command
// - Register mode leaves standby on nonzero
// - Register mode leaves sleep via pin only
// - Sleep exit threshold above standby exit
// - Ninety-six bits of parameter memory
// - Write lasts 24 ms, start clears after
// - Memory copied at power-on and sleep exit
// - Register writes override stored values
module lpn_power_ctrl
  import lpn_pkg::*;
#(
  parameter bit SLEEP_VARIANT = 1'b0,
  parameter int NVM_WRITE_CYCLES = NVM_WRITE_CYCLES_DFLT,
  parameter logic [NVM_BITS-1:0] NVM_INIT = '0
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire lpn_bus_req_t bus_req,
  output logic [7:0] rdata,
  input wire logic speed_pin,
  input wire logic [8:0] speed_level,
  input wire logic [7:0] supply_level,
  input wire lpn_wave_t phase_wave,
  output logic drive_enable,
  output logic regulator_enable,
  output logic serial_enable,
  output logic low_power_flag,
  output logic [8:0] peak_duty_output,
  output logic [6:0] phase_resistance_code,
  output logic [6:0] back_emf_constant_code,
  output logic [7:0] drive_amplitude,
  output lpn_duty_t phase_duty
);

  // ==========================================================
  // Variant-dependent limits
  localparam int PW = $clog2(NVM_WRITE_CYCLES + 1);
  localparam logic [PW-1:0] PROG_LAST = PW'(NVM_WRITE_CYCLES - 1);
  localparam logic [QUAL_W-1:0] EN_ANA =
    SLEEP_VARIANT ? EN_SL_ANA_CYC : EN_SB_ANA_CYC;
  localparam logic [QUAL_W-1:0] EN_PWM =
    SLEEP_VARIANT ? EN_SL_PWM_CYC : EN_SB_PWM_CYC;
  localparam logic [QUAL_W-1:0] EX_ANA =
    SLEEP_VARIANT ? EX_SL_ANA_CYC : EX_SB_ANA_CYC;
  localparam logic [QUAL_W-1:0] EX_PWM =
    SLEEP_VARIANT ? EX_SL_PWM_CYC : EX_SB_PWM_CYC;
  // The sleep part needs a higher level to wake than the standby part.
  localparam logic [8:0] LVL_EN = SLEEP_VARIANT ? LVL_EN_SL : LVL_EN_SB;
  localparam logic [8:0] LVL_EX =
    SLEEP_VARIANT ? LVL_EX_SL : LVL_EX_SB;
  localparam int Q_ENTER = 0;
  localparam int Q_EXIT = 1;

  // ==========================================================
  // State
  lpn_pwr_state_t state_reg, state_next;
  logic [8:0] speed_reg, speed_next;
  logic inhibit_reg, inhibit_next;
  logic [7:0] key_reg, key_next;
  logic select_reg, select_next;
  logic busy_reg, busy_next;
  logic [PW-1:0] prog_cnt_reg, prog_cnt_next;
  logic [PARAM_BYTES-1:0][7:0] param_reg, param_next;
  logic [7:0] rdata_reg, rdata_next;
  logic drive_reg, drive_next;
  logic regen_reg, regen_next;
  logic serial_reg, serial_next;
  logic lp_reg, lp_next;
  logic [8:0] duty_reg, duty_next;
  logic [7:0] nvm_mem [PARAM_BYTES];
  logic nvm_commit;

  logic bus_live;
  logic [3:0] param_idx;
  logic in_param;
  logic [7:0] rd_value;
  lpn_mode_t mode;
  logic [8:0] cmd;
  logic [1:0] q_arm, q_cond, q_done;
  logic [QUAL_W-1:0] q_limit [2];

  // Ninety-six bits, one byte per parameter register.
  initial begin
    for (int i = 0; i < PARAM_BYTES; i++) begin
      nvm_mem[i] = NVM_INIT[i*8 +: 8];
    end
  end

  assign mode = lpn_mode_t'(param_reg[PARAM_MODE_IDX][MODE_LSB +: 2]);
  // The port goes deaf in sleep; standby keeps it answering.
  assign bus_live =
    !(SLEEP_VARIANT && state_reg == ST_LOW_POWER);
  assign param_idx = 4'(bus_req.addr - ADDR_PARAM_BASE);
  assign in_param = (bus_req.addr >= ADDR_PARAM_BASE) &&
                    (bus_req.addr <= ADDR_PARAM_LAST);
  assign cmd = (mode == MODE_ANALOG || mode == MODE_PWM) ?
               speed_level : speed_reg;

  // ==========================================================
  // Entry and exit conditions
  always_comb begin
    q_arm[Q_ENTER] = (state_reg == ST_ACTIVE) && !inhibit_reg;
    q_arm[Q_EXIT] = (state_reg == ST_LOW_POWER);
    case (mode)
      MODE_ANALOG: begin
        q_cond[Q_ENTER] = speed_level < LVL_EN;
        q_cond[Q_EXIT] = speed_level > LVL_EX;
        q_limit[Q_ENTER] = EN_ANA;
        q_limit[Q_EXIT] = EX_ANA;
      end
      MODE_PWM: begin
        q_cond[Q_ENTER] = !speed_pin;
        q_cond[Q_EXIT] = speed_pin;
        q_limit[Q_ENTER] = EN_PWM;
        q_limit[Q_EXIT] = EX_PWM;
      end
      MODE_REG_ANA_PIN: begin
        q_cond[Q_ENTER] = speed_reg == '0;
        q_cond[Q_EXIT] = SLEEP_VARIANT ? (speed_level > LVL_EX) :
                         (speed_reg != '0);
        q_limit[Q_ENTER] = EN_PWM;
        q_limit[Q_EXIT] = SLEEP_VARIANT ? EX_ANA : EX_PWM;
      end
      default: begin
        q_cond[Q_ENTER] = speed_reg == '0;
        q_cond[Q_EXIT] = SLEEP_VARIANT ? speed_pin :
                         (speed_reg != '0);
        q_limit[Q_ENTER] = EN_PWM;
        q_limit[Q_EXIT] = EX_PWM;
      end
    endcase
  end

  generate
    for (genvar q = 0; q < 2; q++) begin : g_qual
      lpn_qual_timer #(
        .W(QUAL_W)
      ) u_timer (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .ce(ce),
        .arm(q_arm[q]),
        .cond(q_cond[q]),
        .limit(q_limit[q]),
        .done(q_done[q])
      );
    end
  endgenerate

  // ==========================================================
  // Read mux
  always_comb begin
    rd_value = 8'h00;
    if (in_param) begin
      rd_value = param_reg[param_idx];
    end else begin
      case (bus_req.addr)
        ADDR_SPEED_LO: rd_value = speed_reg[7:0];
        ADDR_SPEED_HI: rd_value = {7'h00, speed_reg[8]};
        ADDR_CONFIG: rd_value = {inhibit_reg, 7'h00};
        ADDR_DEV_CTRL: rd_value = key_reg;
        ADDR_NVM_CTRL: begin
          rd_value[NVMC_SELECT_BIT] = select_reg;
          rd_value[NVMC_START_BIT] = busy_reg;
        end
        ADDR_STATUS: rd_value[STAT_LOW_POWER_BIT] = lp_reg;
        default: rd_value = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    speed_next = speed_reg;
    inhibit_next = inhibit_reg;
    key_next = key_reg;
    select_next = select_reg;
    busy_next = busy_reg;
    prog_cnt_next = prog_cnt_reg;
    param_next = param_reg;
    rdata_next = 8'h00;
    nvm_commit = 1'b0;

    if (busy_reg) begin
      if (prog_cnt_reg == PROG_LAST) begin
        busy_next = 1'b0;
        nvm_commit = 1'b1;
        prog_cnt_next = '0;
      end else begin
        prog_cnt_next = prog_cnt_reg + 1'b1;
      end
    end

    if (bus_live && bus_req.wr) begin
      if (in_param) begin
        param_next[param_idx] = bus_req.wdata;
      end else begin
        case (bus_req.addr)
          ADDR_SPEED_LO: speed_next[7:0] = bus_req.wdata;
          ADDR_SPEED_HI: speed_next[8] = bus_req.wdata[0];
          ADDR_CONFIG: inhibit_next = bus_req.wdata[CFG_INHIBIT_BIT];
          ADDR_DEV_CTRL: key_next = bus_req.wdata;
          ADDR_NVM_CTRL: begin
            select_next = bus_req.wdata[NVMC_SELECT_BIT];
            if (bus_req.wdata[NVMC_START_BIT]) begin
              // A start without the key and the select bit begins no write but still clears the key.
              if (key_reg == PROGRAM_KEY && select_reg && !busy_reg) begin
                busy_next = 1'b1;
                prog_cnt_next = '0;
              end
              key_next = KEY_RST;
            end
          end
          default: begin
          end
        endcase
      end
    end

    if (bus_live && bus_req.rd) begin
      rdata_next = rd_value;
    end

    case (state_reg)
      ST_LOAD: begin
        for (int i = 0; i < PARAM_BYTES; i++) begin
          param_next[i] = nvm_mem[i];
        end
        state_next = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        if (q_done[Q_ENTER]) begin
          state_next = ST_LOW_POWER;
          if (SLEEP_VARIANT) begin
            speed_next = SPEED_RST;
            inhibit_next = INHIBIT_RST;
            key_next = KEY_RST;
            select_next = SELECT_RST;
          end
        end
      end
      ST_LOW_POWER: begin
        // Sleep loses working values, so waking reloads them.
        if (q_done[Q_EXIT]) begin
          state_next = SLEEP_VARIANT ? ST_LOAD : ST_ACTIVE;
        end
      end
      default: state_next = ST_LOAD;
    endcase

    drive_next = (state_next == ST_ACTIVE);
    lp_next = (state_next == ST_LOW_POWER);
    regen_next = !(SLEEP_VARIANT && lp_next);
    serial_next = regen_next;
    if (state_next != ST_ACTIVE) begin
      duty_next = 9'h000;
    end else if (cmd > DUTY_FULL) begin
      duty_next = DUTY_FULL;
    end else begin
      duty_next = cmd;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_LOAD;
      speed_reg <= SPEED_RST;
      inhibit_reg <= INHIBIT_RST;
      key_reg <= KEY_RST;
      select_reg <= SELECT_RST;
      busy_reg <= 1'b0;
      prog_cnt_reg <= '0;
      param_reg <= '0;
      rdata_reg <= 8'h00;
      drive_reg <= 1'b0;
      regen_reg <= 1'b1;
      serial_reg <= 1'b1;
      lp_reg <= 1'b0;
      duty_reg <= 9'h000;
    end else if (ce) begin
      state_reg <= state_next;
      speed_reg <= speed_next;
      inhibit_reg <= inhibit_next;
      key_reg <= key_next;
      select_reg <= select_next;
      busy_reg <= busy_next;
      prog_cnt_reg <= prog_cnt_next;
      param_reg <= param_next;
      rdata_reg <= rdata_next;
      drive_reg <= drive_next;
      regen_reg <= regen_next;
      serial_reg <= serial_next;
      lp_reg <= lp_next;
      duty_reg <= duty_next;
    end
  end

  // The array survives reset on purpose: it stands for the memory cells.
  // A plain always, since the initial block also writes the array.
  always @(posedge sys_clk) begin
    if (ce && nvm_commit) begin
      for (int i = 0; i < PARAM_BYTES; i++) begin
        nvm_mem[i] <= param_reg[i];
      end
    end
  end

  // ==========================================================
  // Drive shaping
  lpn_drive_shaper u_shaper (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .ce(ce),
    .drive_on(drive_reg),
    .duty(duty_reg),
    .supply(supply_level),
    .wave(phase_wave),
    .amplitude(drive_amplitude),
    .phase_duty(phase_duty)
  );

  assign rdata = rdata_reg;
  assign drive_enable = drive_reg;
  assign regulator_enable = regen_reg;
  assign serial_enable = serial_reg;
  assign low_power_flag = lp_reg;
  assign peak_duty_output = duty_reg;
  assign phase_resistance_code = param_reg[PARAM_RES_IDX][6:0];
  assign back_emf_constant_code = param_reg[PARAM_KT_IDX][6:0];

endmodule

`default_nettype wire

// File: lpn_power_ctrl_chk.sv
// Purpose: Port-level assertions for the low-power and parameter control.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Sleep checks only bite when SLEEP_VARIANT is set.
`default_nettype none

module lpn_power_ctrl_chk
  import lpn_pkg::*;
#(
  parameter bit SLEEP_VARIANT = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire lpn_bus_req_t bus_req,
  input wire logic [7:0] rdata,
  input wire logic drive_enable,
  input wire logic regulator_enable,
  input wire logic serial_enable,
  input wire logic low_power_flag,
  input wire logic [8:0] peak_duty_output,
  input wire logic [7:0] supply_level,
  input wire logic [7:0] drive_amplitude,
  input wire lpn_duty_t phase_duty
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  // ==========================================================
  // Drive output
  a_low_power_idle: assert property (
    low_power_flag |-> !drive_enable) else $error("drive on in low power");
  a_duty_when_off: assert property (
    !drive_enable |-> peak_duty_output == 9'h000)
    else $error("duty not zero while drive off");
  a_entry_from_drive: assert property (
    $rose(low_power_flag) |-> $past(drive_enable))
    else $error("low power entered while not driving");
  a_duty_full_scale: assert property (
    peak_duty_output <= DUTY_FULL) else $error("duty above full scale");
  // The product needs 17 bits; a narrower multiply wraps near full scale.
  a_amp_scaled: assert property (
    ce |=> drive_amplitude == 8'((17'($past(supply_level)) *
      17'($past(peak_duty_output))) >> 8))
    else $error("amplitude not scaled by duty");
  a_one_phase_low: assert property (
    phase_duty[0] == 8'h00 || phase_duty[1] == 8'h00 ||
    phase_duty[2] == 8'h00) else $error("no phase held at ground");

  // ==========================================================
  // Supply and register port
  a_regulator_kept: assert property (
    !SLEEP_VARIANT |-> regulator_enable && serial_enable)
    else $error("standby part switched regulator or port off");
  a_sleep_shutdown: assert property (
    SLEEP_VARIANT && low_power_flag |-> !regulator_enable && !serial_enable)
    else $error("regulator or port still on in sleep");
  a_sleep_deaf: assert property (
    SLEEP_VARIANT && low_power_flag && bus_req.rd |=> rdata == 8'h00)
    else $error("read answered in sleep");
  a_status_read: assert property (
    bus_req.rd && bus_req.addr == ADDR_STATUS && serial_enable |=>
      rdata[STAT_LOW_POWER_BIT] == $past(low_power_flag))
    else $error("status bit does not show low power");

  c_enter: cover property ($rose(low_power_flag));
  c_leave: cover property ($fell(low_power_flag));
  c_status: cover property (bus_req.rd && bus_req.addr == ADDR_STATUS);
endmodule

`default_nettype wire

// File: lpn_host_model.sv
// Purpose: Host controller and speed pin source facing the block.
// Assumes: Tasks are called from one process at a time.
// Notes:   Idle address and data are inverted and strobes cleared so stale values never look valid.
`default_nettype none

module lpn_host_model
  import lpn_pkg::*;
(
  input wire logic sys_clk,
  output var lpn_bus_req_t bus_req,
  output logic speed_pin,
  output logic [8:0] speed_level
);
  initial begin
    bus_req = '0;
    speed_pin = 1'b1;
    speed_level = 9'h080;
  end

  // ==========================================================
  // Register port, one strobe cycle per transfer
  task automatic xfer(input logic [7:0] a, input logic [7:0] d,
    input logic w);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge sys_clk);
    bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask

  task automatic pins(input logic p, input logic [8:0] lvl, input int n);
    @(posedge sys_clk);
    speed_pin <= p;
    speed_level <= lvl;
    repeat (n - 1) @(posedge sys_clk);
    #1;
  endtask

  // Byte 0 holds the resistance code and byte 1 the back-EMF code.
  task automatic nvm_program(input logic [95:0] img);
    xfer(ADDR_NVM_CTRL, 8'h40, 1'b1);
    for (int i = 0; i < PARAM_BYTES; i++) begin
      xfer(8'(ADDR_PARAM_BASE + i), img[i*8 +: 8], 1'b1);
    end
    xfer(ADDR_DEV_CTRL, PROGRAM_KEY, 1'b1);
    xfer(ADDR_NVM_CTRL, 8'h41, 1'b1);
  endtask
endmodule

`default_nettype wire

// File: low_power_and_nvm_program_ctrl_test.sv
// Purpose: Self-checking bench for the low-power and parameter control.
// Assumes: Standby part, short memory write time.
// Notes:   Sleep behaviour is left to the assertions.
`default_nettype none

module low_power_and_nvm_program_ctrl_test
  import lpn_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WR_CYC = 50;
  localparam logic [95:0] INIT_IMG = {8'h01, 72'h0, 8'h4a, 8'h35};
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  lpn_bus_req_t bus_req;
  logic speed_pin;
  logic [8:0] speed_level;
  logic [7:0] supply_level = 8'h80;
  lpn_wave_t phase_wave = '0;
  logic [7:0] rdata, drive_amplitude;
  logic drive_enable, regulator_enable, serial_enable, low_power_flag;
  logic [8:0] peak_duty_output;
  logic [6:0] phase_resistance_code, back_emf_constant_code;
  lpn_duty_t phase_duty;
  int seed = 62072;
  int miscompares = 0;
  int checked = 0;
  logic rd_d = 1'b0;
  logic [7:0] exp_q [$];

  lpn_power_ctrl #(.SLEEP_VARIANT(1'b0), .NVM_WRITE_CYCLES(WR_CYC),
    .NVM_INIT(INIT_IMG)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .bus_req(bus_req),
    .rdata(rdata), .speed_pin(speed_pin), .speed_level(speed_level),
    .supply_level(supply_level), .phase_wave(phase_wave),
    .drive_enable(drive_enable), .regulator_enable(regulator_enable),
    .serial_enable(serial_enable), .low_power_flag(low_power_flag),
    .peak_duty_output(peak_duty_output),
    .phase_resistance_code(phase_resistance_code),
    .back_emf_constant_code(back_emf_constant_code),
    .drive_amplitude(drive_amplitude), .phase_duty(phase_duty));
  lpn_host_model host (.sys_clk(sys_clk), .bus_req(bus_req),
    .speed_pin(speed_pin), .speed_level(speed_level));

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Checking
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (miscompares == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.xfer(a, 8'h00, 1'b0);
  endtask

  // Read data stands only in the cycle after the strobe.
  always @(posedge sys_clk) begin
    rd_d <= bus_req.rd;
    if (rd_d && exp_q.size() > 0) begin
      check(rdata, exp_q.pop_front());
    end
  end

  always @(posedge sys_clk) begin
    phase_wave <= lpn_wave_t'(24'($random(seed)));
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    results();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [95:0] img;
    logic [8:0] d;
    logic [7:0] regs [6];
    regs = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h3f};
    img = {8'h01, 32'($random(seed)), 32'($random(seed)),
      24'($random(seed))};
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    host.pins(1'b1, 9'h080, 4);
    check(phase_resistance_code, 7'h35);
    check(back_emf_constant_code, 7'h4a);
    foreach (regs[i]) rd_exp(regs[i], 8'h00);
    host.xfer(ADDR_CONFIG, 8'h80, 1'b1);
    host.pins(1'b0, 9'h080, 3800);
    check(low_power_flag, 1'b0);
    host.xfer(ADDR_CONFIG, 8'h00, 1'b1);
    host.pins(1'b1, 9'h080, 2);
    host.pins(1'b0, 9'h080, 3740);
    check(low_power_flag, 1'b0);
    host.pins(1'b1, 9'h080, 2);
    host.pins(1'b0, 9'h080, 3740);
    check(low_power_flag, 1'b0);
    host.pins(1'b0, 9'h080, 30);
    check(low_power_flag, 1'b1);
    check(drive_enable, 1'b0);
    host.xfer(ADDR_CONFIG, 8'h80, 1'b1);
    rd_exp(ADDR_STATUS, 8'h40);
    rd_exp(ADDR_CONFIG, 8'h80);
    host.pins(1'b0, 9'h080, 3);
    check(low_power_flag, 1'b1);
    host.pins(1'b1, 9'h080, 1240);
    check(low_power_flag, 1'b1);
    host.pins(1'b1, 9'h080, 30);
    check(low_power_flag, 1'b0);
    host.xfer(ADDR_CONFIG, 8'h00, 1'b1);
    host.xfer(ADDR_PARAM_LAST, 8'h00, 1'b1);
    host.pins(1'b1, 9'h008, 2530);
    check(low_power_flag, 1'b1);
    host.pins(1'b1, 9'h018, 1300);
    check(low_power_flag, 1'b1);
    host.pins(1'b1, 9'h030, 1240);
    check(low_power_flag, 1'b1);
    host.pins(1'b1, 9'h030, 30);
    check(low_power_flag, 1'b0);
    host.xfer(ADDR_PARAM_LAST, 8'h02, 1'b1);
    host.pins(1'b1, 9'h080, 3770);
    check(low_power_flag, 1'b1);
    host.xfer(ADDR_SPEED_LO, 8'h05, 1'b1);
    host.pins(1'b1, 9'h080, 1240);
    check(low_power_flag, 1'b1);
    host.pins(1'b1, 9'h080, 30);
    check(low_power_flag, 1'b0);
    for (int k = 0; k < 2; k++) begin
      d = k ? 9'h080 : DUTY_FULL;
      host.xfer(ADDR_SPEED_HI, {7'h00, d[8]}, 1'b1);
      host.xfer(ADDR_SPEED_LO, d[7:0], 1'b1);
      supply_level <= 8'($random(seed));
      host.pins(1'b1, 9'h080, 4);
      check(peak_duty_output, d);
      check(drive_amplitude, k ? supply_level >> 1 : supply_level);
    end
    host.xfer(ADDR_NVM_CTRL, 8'h41, 1'b1);
    rd_exp(ADDR_NVM_CTRL, 8'h40);
    host.nvm_program(img);
    rd_exp(ADDR_NVM_CTRL, 8'h41);
    rd_exp(ADDR_DEV_CTRL, 8'h00);
    check(phase_resistance_code, img[6:0]);
    host.pins(1'b1, 9'h080, WR_CYC + 4);
    rd_exp(ADDR_NVM_CTRL, 8'h40);
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    host.pins(1'b1, 9'h080, 4);
    check(phase_resistance_code, img[6:0]);
    check(back_emf_constant_code, img[14:8]);
    for (int i = 0; i < PARAM_BYTES; i++) begin
      rd_exp(8'(ADDR_PARAM_BASE + i), img[i*8 +: 8]);
    end
    ce <= 1'b0;
    host.xfer(ADDR_CONFIG, 8'h80, 1'b1);
    ce <= 1'b1;
    rd_exp(ADDR_CONFIG, 8'h00);
    host.pins(1'b1, 9'h080, 4);
    results();
  end
endmodule

bind lpn_power_ctrl lpn_power_ctrl_chk #(.SLEEP_VARIANT(SLEEP_VARIANT)) u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .bus_req(bus_req),
  .rdata(rdata), .drive_enable(drive_enable),
  .regulator_enable(regulator_enable), .serial_enable(serial_enable),
  .low_power_flag(low_power_flag), .peak_duty_output(peak_duty_output),
  .supply_level(supply_level), .drive_amplitude(drive_amplitude),
  .phase_duty(phase_duty));

`default_nettype wire
